// ==== hdl/clkctl_pkg.sv ====
/*
 Constants for the system clock divider and PLL control block: register
 offsets, field positions, reset values and timing counts.
 Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
// How it works
// - change-enable captured only when all other divider bits are written zero.
// - change-enable clears four cycles after set, or when select is written.
// - rewriting change-enable inside its window neither restarts nor clears it.
// - select code n divides by two to the n, codes 0..8; others reserved.
// - divided clock enable drives the CPU and all synchronous peripherals.
// - select resets to 0000, or 0011 when divide-by-eight fuse is programmed.
// - any select value is accepted later, whatever the fuse.
// - factor changes glitch-free, no period shorter than old or new.
// - new factor active within old period plus one to two new periods.
// - reserved PLL control bits always read zero.
// - input-halve bit passes or halves the prescaled system clock source (select zero); set before enabling.
// - PLL enable starts PLL; with source select set, RC oscillator runs.
// - lock reads one once locked, clears only when enable is cleared.
// - lock stays zero for a settling period after enabling.
// - source select zero feeds prescaled system clock, one the RC oscillator.
// - USB halve bit passes PLL output when zero, halves it when one.
// - timer post-divider: 00 off, 01 by 1, 10 by 1.5, 11 by 2.
// - divide-by-1.5 keeps average duty at fifty percent.
// - frequency codes 3,4,5,7,8,9,10 give 40..96 MHz; others not allowed.
package clkctl_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADDR_DIV_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PLL_CSR = 4'h4;
   localparam logic [3:0] ADDR_PLL_FRQ = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   // ----------------------------------------
   // Fields
   // ----------------------------------------
   localparam int DIV_CE_BIT = 7;
   localparam int PLL_HALVE_BIT = 4;
   localparam int PLL_EN_BIT = 1;
   localparam int PLL_LOCK_BIT = 0;
   localparam int SRC_SEL_BIT = 7;
   localparam int USB_HALVE_BIT = 6;
   localparam int TM_LSB = 4;
   localparam logic [3:0] SEL_RST_PLAIN = 4'h0;
   localparam logic [3:0] SEL_RST_FUSE = 4'h3;
   localparam logic [3:0] SEL_MAX = 4'h8;
   localparam logic [7:0] FRQ_RST = 8'h04;
   localparam logic [1:0] TM_OFF = 2'h0;
   localparam logic [1:0] TM_DIV1 = 2'h1;
   localparam logic [1:0] TM_DIV15 = 2'h2;
   localparam logic [2:0] CE_WINDOW = 3'h4;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int LOCK_TIME_US = 2000;
   localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
   // Edges after reset release before the synchronised fuse level is trusted
   localparam logic [2:0] SYNC_FILL = 3'h4;
endpackage

// ==== hdl/pll_postdiv.sv ====
/*
 Post-dividers fed by the PLL output clock enable: USB halve and
 timer divider (off, 1, 1.5, 2). Runs on mclk with pll_tick as enable.
 Assumes pll_tick is a one-cycle pulse per PLL output period.
*/
`timescale 1ns/1ps
module pll_postdiv (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic pll_tick,
   input wire logic usb_halve,
   input wire logic [1:0] tm_sel,
   output logic usb_tick,
   output logic tm_tick
);
   logic usb_ph_ff;
   logic [1:0] tm_cnt_ff;
   logic usb_ff;
   logic tm_ff;
   wire tm_fire;
   // Divide by 1.5: two outputs every three input periods, even on average
   assign tm_fire = (tm_sel == clkctl_pkg::TM_DIV1) ? 1'b1 :
                    (tm_sel == clkctl_pkg::TM_DIV15) ? (tm_cnt_ff != 2'h2) :
                    (tm_sel == clkctl_pkg::TM_OFF) ? 1'b0 : usb_ph_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         usb_ph_ff <= 1'b0;
         tm_cnt_ff <= 2'h0;
         usb_ff <= 1'b0;
         tm_ff <= 1'b0;
      end else if (ce) begin
         usb_ff <= pll_tick & (~usb_halve | usb_ph_ff);
         tm_ff <= pll_tick & tm_fire;
         if (pll_tick) begin
            usb_ph_ff <= ~usb_ph_ff;
            tm_cnt_ff <= (tm_cnt_ff == 2'h2) ? 2'h0 : tm_cnt_ff + 2'h1;
         end
      end
   end
   assign usb_tick = usb_ff;
   assign tm_tick = tm_ff;
endmodule

// ==== hdl/sysclk_divider_and_pll_ctrl.sv ====
/*
 System clock divider with protected change sequence and PLL control/status,
 reached over Avalon-MM. Clock outputs are one-cycle enables on mclk.
 Assumes fuse and pll_ref_ok come from outside the clock domain.
*/
`timescale 1ns/1ps
module sysclk_divider_and_pll_ctrl #(
   parameter int LOCK_CYCLES = clkctl_pkg::LOCK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic divide_by_eight_fuse,
   input wire logic pll_ref_ok,
   output logic sys_clk_en,
   output logic rc_osc_on,
   output logic pll_running,
   output logic pll_tick,
   output logic usb_tick,
   output logic tm_tick
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [2:0] fuse_sync_ff;
   logic [2:0] ref_sync_ff;
   logic fuse_ff;
   logic ref_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fuse_sync_ff <= 3'h0;
         ref_sync_ff <= 3'h0;
         fuse_ff <= 1'b0;
         ref_ff <= 1'b0;
      end else if (ce) begin
         fuse_sync_ff <= {fuse_sync_ff[1:0], divide_by_eight_fuse};
         ref_sync_ff <= {ref_sync_ff[1:0], pll_ref_ok};
         if (fuse_sync_ff[1] == fuse_sync_ff[2]) begin
            fuse_ff <= fuse_sync_ff[2];
         end
         if (ref_sync_ff[1] == ref_sync_ff[2]) begin
            ref_ff <= ref_sync_ff[2];
         end
      end
   end

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } bus_state_t;
   bus_state_t bus_ff;
   wire req = avs_read | avs_write;
   wire acc = (bus_ff == BUS_ACK);
   wire wr = acc & avs_write & avs_byteenable[0];
   wire sel_div = (avs_address == clkctl_pkg::ADDR_DIV_CTRL);
   wire sel_csr = (avs_address == clkctl_pkg::ADDR_PLL_CSR);
   wire sel_frq = (avs_address == clkctl_pkg::ADDR_PLL_FRQ);
   wire sel_sta = (avs_address == clkctl_pkg::ADDR_STATUS);
   wire [7:0] wd = avs_writedata[7:0];
   wire wr_div = wr & sel_div;
   wire wr_csr = wr & sel_csr;
   wire wr_frq = wr & sel_frq;
   assign avs_waitrequest = req & ~acc;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_ff <= BUS_IDLE;
      end else if (ce) begin
         case (bus_ff)
            BUS_IDLE: bus_ff <= req ? BUS_ACK : BUS_IDLE;
            BUS_ACK: bus_ff <= BUS_IDLE;
            default: bus_ff <= BUS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Divider control word
   // ----------------------------------------
   logic ce_bit_ff;
   logic [2:0] ce_cnt_ff;
   logic [3:0] sel_ff;
   logic [3:0] act_sel_ff;
   logic init_ff;
   logic [2:0] fill_ff;
   logic sel_rsv_ff;
   wire ce_arm = wr_div & wd[clkctl_pkg::DIV_CE_BIT] & (wd[6:0] == 7'h00);
   wire sel_wr = wr_div & ~wd[clkctl_pkg::DIV_CE_BIT] & ce_bit_ff;
   wire sel_rsv = (wd[3:0] > clkctl_pkg::SEL_MAX);
   wire ce_expire = ce_bit_ff & (ce_cnt_ff == clkctl_pkg::CE_WINDOW - 3'h1);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ce_bit_ff <= 1'b0;
         ce_cnt_ff <= 3'h0;
         sel_ff <= clkctl_pkg::SEL_RST_PLAIN;
         init_ff <= 1'b1;
         fill_ff <= 3'h0;
         sel_rsv_ff <= 1'b0;
      end else if (ce) begin
         // Fuse level caught once the synchroniser has filled and settled
         if (init_ff & (fill_ff != clkctl_pkg::SYNC_FILL)) begin
            fill_ff <= fill_ff + 3'h1;
         end
         if (init_ff & (fill_ff == clkctl_pkg::SYNC_FILL) & (fuse_sync_ff[2] == fuse_ff)) begin
            init_ff <= 1'b0;
            sel_ff <= fuse_ff ? clkctl_pkg::SEL_RST_FUSE : clkctl_pkg::SEL_RST_PLAIN;
         end else if (sel_wr) begin
            sel_ff <= wd[3:0];
            sel_rsv_ff <= sel_rsv;
         end
         if (sel_wr | ce_expire) begin
            ce_bit_ff <= 1'b0;
            ce_cnt_ff <= 3'h0;
         end else if (ce_bit_ff) begin
            ce_cnt_ff <= ce_cnt_ff + 3'h1;
         end else if (ce_arm) begin
            ce_bit_ff <= 1'b1;
            ce_cnt_ff <= 3'h0;
         end
      end
   end

   // ----------------------------------------
   // Divider counter and glitch-free switch
   // ----------------------------------------
   // Free counter; the active factor changes only at a terminal count of the
   // old factor, so the next period is a full new period.
   logic [7:0] div_cnt_ff;
   logic en_ff;
   wire [3:0] eff_sel = (act_sel_ff > clkctl_pkg::SEL_MAX) ? clkctl_pkg::SEL_MAX : act_sel_ff;
   wire [7:0] div_mask = 8'((9'h001 << eff_sel) - 9'h001);
   wire div_tc = ((div_cnt_ff & div_mask) == div_mask);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt_ff <= 8'h00;
         act_sel_ff <= clkctl_pkg::SEL_RST_PLAIN;
         en_ff <= 1'b0;
      end else if (ce) begin
         en_ff <= div_tc;
         if (div_tc) begin
            div_cnt_ff <= 8'h00;
            act_sel_ff <= sel_ff;
         end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
         end
      end
   end
   assign sys_clk_en = en_ff;

   // ----------------------------------------
   // PLL control and status
   // ----------------------------------------
   logic halve_ff;
   logic pll_en_ff;
   logic lock_ff;
   logic [31:0] lock_cnt_ff;
   logic [7:0] frq_ff;
   logic [3:0] vco_cnt_ff;
   logic pll_tick_ff;
   logic in_ph_ff;
   wire [3:0] fsel = frq_ff[3:0];
   wire fsel_ok = (fsel == 4'h3) | (fsel == 4'h4) | (fsel == 4'h5) | (fsel == 4'h7) |
                  (fsel == 4'h8) | (fsel == 4'h9) | (fsel == 4'hA);
   // Enable as it will be after this edge, so lock and ticks stop with it
   wire en_nxt = wr_csr ? wd[clkctl_pkg::PLL_EN_BIT] : pll_en_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         halve_ff <= 1'b0;
         pll_en_ff <= 1'b0;
         lock_ff <= 1'b0;
         lock_cnt_ff <= 32'h0000_0000;
         frq_ff <= clkctl_pkg::FRQ_RST;
      end else if (ce) begin
         if (wr_csr) begin
            halve_ff <= wd[clkctl_pkg::PLL_HALVE_BIT];
            pll_en_ff <= wd[clkctl_pkg::PLL_EN_BIT];
         end
         if (wr_frq) begin
            frq_ff <= wd;
         end
         if (~en_nxt) begin
            lock_ff <= 1'b0;
            lock_cnt_ff <= 32'h0000_0000;
         end else if (lock_cnt_ff < 32'(LOCK_CYCLES)) begin
            lock_cnt_ff <= lock_cnt_ff + 32'h0000_0001;
         end else if (ref_ff & fsel_ok) begin
            lock_ff <= 1'b1;
         end
      end
   end
   wire src_rc = frq_ff[clkctl_pkg::SRC_SEL_BIT];
   assign rc_osc_on = pll_en_ff & src_rc;
   assign pll_running = pll_en_ff;

   // Modelled PLL output: one tick every (16 - code) input phases
   wire in_tick = src_rc | ~halve_ff | in_ph_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vco_cnt_ff <= 4'h0;
         pll_tick_ff <= 1'b0;
         in_ph_ff <= 1'b0;
      end else if (ce) begin
         in_ph_ff <= ~in_ph_ff;
         pll_tick_ff <= 1'b0;
         if (lock_ff & en_nxt & in_tick) begin
            if (vco_cnt_ff >= 4'hF - fsel) begin
               vco_cnt_ff <= 4'h0;
               pll_tick_ff <= 1'b1;
            end else begin
               vco_cnt_ff <= vco_cnt_ff + 4'h1;
            end
         end
      end
   end
   assign pll_tick = pll_tick_ff;
   wire tick_gate = pll_tick_ff & en_nxt;

   pll_postdiv u_postdiv (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .pll_tick(tick_gate),
      .usb_halve(frq_ff[clkctl_pkg::USB_HALVE_BIT]),
      .tm_sel(frq_ff[clkctl_pkg::TM_LSB +: 2]),
      .usb_tick(usb_tick),
      .tm_tick(tm_tick)
   );

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] rd_ff;
   wire [7:0] div_rd = {ce_bit_ff, 3'h0, sel_ff};
   wire [7:0] csr_rd = {3'h0, halve_ff, 2'h0, pll_en_ff, lock_ff};
   wire [7:0] sta_rd = {5'h00, sel_rsv_ff, fsel_ok, init_ff};
   wire [7:0] rd_mux = sel_div ? div_rd : sel_csr ? csr_rd : sel_frq ? frq_ff : sel_sta ? sta_rd : 8'h00;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_ff <= 32'h0000_0000;
      end else if (ce) begin
         if (avs_read & ~acc) begin
            rd_ff <= {24'h00_0000, rd_mux};
         end
      end
   end
   assign avs_readdata = rd_ff;
endmodule

// ==== verif/sysclk_divider_and_pll_ctrl_sva.sv ====
/*
 Checker for the clock control block: PLL flags, lock wait, divider gaps, reads.
 Assumes it is bound into the top module and sees its ports only.
*/
`timescale 1ns/1ps
module sysclk_divider_and_pll_ctrl_sva #(
   parameter int LOCK_CYCLES = clkctl_pkg::LOCK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic sys_clk_en,
   input wire logic rc_osc_on,
   input wire logic pll_running,
   input wire logic pll_tick,
   input wire logic usb_tick,
   input wire logic tm_tick
);
   logic [8:0] gap_ff;
   logic [7:0] since_ff;
   int run_ff;
   wire rd_ack = avs_read && !avs_waitrequest;
   wire set_ack = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_writedata[7:0] == 8'h80;
   wire [8:0] nxt_gap = sys_clk_en ? 9'h000 : gap_ff + 9'h001;
   wire [7:0] nxt_since = set_ack ? 8'h00 : (since_ff == 8'hff ? since_ff : since_ff + 8'h01);
   int nxt_run;
   assign nxt_run = !pll_running ? 0 : (run_ff >= LOCK_CYCLES ? run_ff : run_ff + 1);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gap_ff <= 9'h000;
         since_ff <= 8'hff;
         run_ff <= 0;
      end else begin
         gap_ff <= nxt_gap;
         since_ff <= nxt_since;
         run_ff <= nxt_run;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   rc_osc_a: assert property (rc_osc_on |-> pll_running)
      else $error("oscillator on without PLL enable");
   tick_run_a: assert property (pll_tick |-> pll_running && run_ff >= LOCK_CYCLES - 2)
      else $error("PLL tick without enable or settling");
   post_run_a: assert property (usb_tick || tm_tick |-> pll_running)
      else $error("post divided tick without PLL");
   gap_max_a: assert property (gap_ff <= 9'h0ff)
      else $error("divided clock gap above 256");
   csr_resv_a: assert property (rd_ack && avs_address == 4'h4 |-> avs_readdata[7:5] == 3'h0 && avs_readdata[3:2] == 2'h0)
      else $error("reserved PLL bits not zero");
   lock_en_a: assert property (rd_ack && avs_address == 4'h4 && avs_readdata[0] |-> avs_readdata[1] && pll_running)
      else $error("lock shown without enable");
   lock_wait_a: assert property (rd_ack && avs_address == 4'h4 && avs_readdata[0] |-> run_ff >= LOCK_CYCLES - 2)
      else $error("lock shown before settling");
   ce_timeout_a: assert property (rd_ack && avs_address == 4'h0 && avs_readdata[7] |-> since_ff <= 8'h06)
      else $error("change enable open too long");
   lock_cov: cover property (rd_ack && avs_address == 4'h4 && avs_readdata[0]);
   gap8_cov: cover property (sys_clk_en && gap_ff == 9'h007);
   open_cov: cover property (rd_ack && avs_address == 4'h0 && avs_readdata[7]);
endmodule
bind sysclk_divider_and_pll_ctrl sysclk_divider_and_pll_ctrl_sva #(.LOCK_CYCLES(LOCK_CYCLES)) u_sva (.mclk(mclk),
   .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_clk_en(sys_clk_en), .rc_osc_on(rc_osc_on),
   .pll_running(pll_running), .pll_tick(pll_tick), .usb_tick(usb_tick), .tm_tick(tm_tick));

// ==== verif/sysclk_divider_and_pll_ctrl_test.sv ====
/*
 Self-checking bench for the clock control block over Avalon-MM.
 Assumes the checker is bound in and the lock count is shortened to 20.
*/
`timescale 1ns/1ps
module sysclk_divider_and_pll_ctrl_test;
   typedef struct {logic wr; logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic mclk, rst, ce, avs_read, avs_write, fuse, ref_ok;
   logic avs_waitrequest, sys_clk_en, rc_osc_on, pll_running, pll_tick, usb_tick, tm_tick;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0] q;
   int err_count, checked, p, n, t;
   row_t rows [8] = '{'{0, 4'h8, 8'h00, 8'h04}, '{1, 4'h8, 8'ha5, 8'h00}, '{0, 4'h8, 8'h00, 8'ha5},
      '{1, 4'h4, 8'hfd, 8'h00}, '{0, 4'h4, 8'h00, 8'h10}, '{1, 4'h2, 8'hff, 8'h00}, '{0, 4'h2, 8'h00, 8'h00},
      '{1, 4'h4, 8'h00, 8'h00}};
   sysclk_divider_and_pll_ctrl #(.LOCK_CYCLES(20)) dut (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .divide_by_eight_fuse(fuse),
      .pll_ref_ok(ref_ok), .sys_clk_en(sys_clk_en), .rc_osc_on(rc_osc_on), .pll_running(pll_running),
      .pll_tick(pll_tick), .usb_tick(usb_tick), .tm_tick(tm_tick));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      #400000;
      err_count++;
      close_out();
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task close_out;
      $display("counts: %0d checked, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task cmp_reg(string nm, logic [7:0] e, logic [7:0] s);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task cmp_cnt(string nm, int e, int s);
      checked++;
      if (s != e) begin
         err_count++;
         $display("mismatch %s expected %0d seen %0d", nm, e, s);
      end
   endtask
   task acc(logic wr, logic [3:0] a, logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin @(posedge mclk); end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
   endtask
   task idle;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   task boot(logic f);
      fuse <= f;
      rst <= 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      n = 0;
      do begin acc(0, 4'hc, 8'h00); n++; end while (q[0] !== 1'b0);
      idle();
   endtask
   task period;
      n = 0;
      p = 0;
      do begin @(posedge mclk); n++; end while (sys_clk_en !== 1'b1 && n < 600);
      do begin @(posedge mclk); p++; end while (sys_clk_en !== 1'b1 && p < 600);
   endtask
   // Unknown ticks count as ticks, so they show up as a mismatch
   task count_ticks;
      n = 0;
      p = 0;
      t = 0;
      repeat (360) begin
         @(posedge mclk);
         n += (pll_tick !== 1'b0);
         p += (usb_tick !== 1'b0);
         t += (tm_tick !== 1'b0);
      end
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {ce, avs_read, avs_write, ref_ok} = 4'b1001;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      err_count = 0;
      checked = 0;
      boot(1'b1);
      for (int i = 0; i < 8; i++) begin
         acc(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) cmp_reg("row", rows[i].e, q);
      end
      idle();
      $display("test rows done");
      acc(0, 4'h0, 8'h00); idle(); cmp_reg("select fused", 8'h03, q);
      period(); period(); cmp_cnt("period fused", 8, p);
      ce <= 1'b0;
      n = 0;
      repeat (20) begin
         @(posedge mclk);
         n += (sys_clk_en !== 1'b0);
      end
      cmp_cnt("frozen", 0, n);
      ce <= 1'b1;
      period(); cmp_cnt("thawed", 8, p);
      acc(1, 4'h0, 8'h80); acc(1, 4'h0, 8'h05); acc(0, 4'h0, 8'h00); idle(); cmp_reg("select", 8'h05, q);
      period(); period(); cmp_cnt("period new", 32, p);
      acc(1, 4'h0, 8'h02); acc(1, 4'h0, 8'h81); acc(1, 4'h0, 8'h02); acc(0, 4'h0, 8'h00); idle();
      cmp_reg("guarded", 8'h05, q);
      acc(1, 4'h0, 8'h80); acc(0, 4'h0, 8'h00); idle(); cmp_reg("open", 8'h85, q);
      repeat (8) @(posedge mclk);
      acc(1, 4'h0, 8'h01); acc(0, 4'h0, 8'h00); idle(); cmp_reg("expired", 8'h05, q);
      acc(1, 4'h0, 8'h80); acc(1, 4'h0, 8'h80); idle(); acc(1, 4'h0, 8'h01); acc(0, 4'h0, 8'h00); idle();
      cmp_reg("no restart", 8'h05, q);
      $display("test divider done");
      acc(1, 4'h8, 8'h84); acc(1, 4'h4, 8'h02); acc(0, 4'h4, 8'h00); idle(); cmp_reg("settling", 8'h02, q);
      cmp_reg("osc run", 8'h03, {6'h00, rc_osc_on, pll_running});
      repeat (80) @(posedge mclk);
      acc(0, 4'h4, 8'h00); idle(); cmp_reg("locked", 8'h03, q);
      n = 0;
      repeat (200) begin @(posedge mclk); n += (tm_tick !== 1'b0); end
      cmp_cnt("timer off", 0, n);
      acc(1, 4'h8, 8'hea); idle(); repeat (4) @(posedge mclk); count_ticks();
      cmp_cnt("pll ticks", 60, n);
      cmp_cnt("usb ticks", 30, p);
      cmp_cnt("timer 1.5", 40, t);
      acc(1, 4'h8, 8'hfa); idle(); repeat (4) @(posedge mclk); count_ticks();
      cmp_cnt("timer 2", 30, t);
      acc(1, 4'h4, 8'h00); acc(0, 4'h4, 8'h00); idle(); cmp_reg("unlocked", 8'h00, q);
      cmp_reg("osc stop", 8'h00, {6'h00, rc_osc_on, pll_running});
      $display("test pll done");
      boot(1'b0);
      acc(0, 4'h0, 8'h00); idle(); cmp_reg("select plain", 8'h00, q);
      period(); cmp_cnt("period plain", 1, p);
      $display("test reset done");
      close_out();
   end
endmodule
